// *** verilog/output_stage_delay_force.sv ***
// output stage: link OR, polarity, programmable delay, fault policy, override, monitor
//
// Functional notes
// [R1] per-channel polarity select, pass or invert, non-inverting after reset
// [R2] per-channel step count 0 to 64, default 0, zero bypasses delay
// [R3] unit selectable 12.5ns up to 1ms or sync, default 12.5ns
// [R4] applied delay is unit time times step count on every transition
// [R5] sync unit forces one step, output changes only at each sync pulse
// [R6] without sync pulses a sync-unit channel keeps its output unchanged
// [R7] realised delay may deviate from nominal by up to one unit
// [R8] controller error applies per-channel policy: off, on or hold, default off
// [R9] the same policy applies while hardware logic control is stopped
// [R10] under fault policy the level ignores the polarity selection
// [R11] override-enable word, bit 1 enables override for its channel
// [R12] override-value word gives forced level, 1 on and 0 off
// [R13] overridden channel follows override value, linked inputs ignored
// [R14] monitor word reflects the actual state of every output terminal
// [R15] bits 0-7 single-ended, 8-13 differential, 14-15 read zero
// [R16] ssi clock routed to a differential channel whose settings lock to defaults
// [R17] each channel ORs all its linked internal signals first
// [R18] only differential outputs 0 and 1 may carry the ssi clock
// [R19] eight single-ended and six differential output channels
// [R20] differential legs are complements of the channel level
// [R21] delay as per-channel shift chain with unit-rate tick enables
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module output_stage_delay_force #(
    parameter int MS_TICK_CYCLES = output_stage_pkg::CYC_1MS
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [output_stage_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [output_stage_pkg::NUM_CH*output_stage_pkg::LINKS-1:0] linkSignals,
    input wire logic [output_stage_pkg::NUM_SSI-1:0] ssiPresent,
    input wire logic [output_stage_pkg::NUM_SSI-1:0] ssiClock,
    input wire logic syncPulse,
    input wire logic cpuError,
    input wire logic logicStop,
    output logic [output_stage_pkg::NUM_SE-1:0] seOut,
    output logic [output_stage_pkg::NUM_DIFF-1:0] diffOutP,
    output logic [output_stage_pkg::NUM_DIFF-1:0] diffOutN
);
    import output_stage_pkg::*;

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] ovrEnable;
    logic [NUM_CH-1:0] ovrValue;
    logic [NUM_CH-1:0] cfgPol;
    logic [STEP_W-1:0] cfgStep [NUM_CH];
    logic [UNIT_W-1:0] cfgUnit [NUM_CH];
    logic [1:0] cfgFault [NUM_CH];
    logic [NUM_CH-1:0] pinLevel;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire setupPhase = psel & ~penable;
    wire accessWrite = psel & penable & pwrite & clkEn;
    wire [ADDR_W-1:0] chOffset = paddr - CHCFG_BASE_OFS;
    wire [ADDR_W-3:0] chIndex = chOffset[ADDR_W-1:2];
    wire hitOvrEn = paddr == OVR_EN_OFS;
    wire hitOvrVal = paddr == OVR_VAL_OFS;
    wire hitMonitor = paddr == MONITOR_OFS;
    wire hitChCfg = (paddr >= CHCFG_BASE_OFS) && (paddr[1:0] == 2'b00) && (chIndex < NUM_CH[ADDR_W-3:0]);
    wire addrMapped = hitOvrEn | hitOvrVal | hitMonitor | hitChCfg;
    wire [3:0] chSel = chIndex[3:0];
    // monitor is read-only: a write to it is answered with an error
    wire badAccess = ~addrMapped | (pwrite & hitMonitor);

    // an out-of-range step is clamped so the delay tap can never run past the chain; bad unit or fault codes load 12.5 ns or off
    wire [STEP_W-1:0] wrStep = (pwdata[STEP_LSB +: STEP_W] > STEP_W'(MAX_STEP))
        ? STEP_W'(MAX_STEP) : pwdata[STEP_LSB +: STEP_W];
    wire [UNIT_W-1:0] wrUnit = (pwdata[UNIT_LSB +: UNIT_W] > UNIT_SYNC) ? UNIT_12NS5 : pwdata[UNIT_LSB +: UNIT_W];
    wire [1:0] wrFault = (pwdata[FAULT_LSB +: 2] > FAULT_HOLD) ? FAULT_OFF : pwdata[FAULT_LSB +: 2];

    wire [WORD_W-1:0] ovrEnWord = {2'b00, ovrEnable}; // R15
    wire [WORD_W-1:0] ovrValWord = {2'b00, ovrValue}; // R15
    wire [WORD_W-1:0] monitorWord = {2'b00, pinLevel}; // R14
    wire [31:0] chCfgWord = {10'h000, cfgFault[chSel], cfgUnit[chSel], 1'b0, cfgStep[chSel], 7'h00, cfgPol[chSel]};
    wire [31:0] readWord = hitOvrEn ? {16'h0000, ovrEnWord}
        : hitOvrVal ? {16'h0000, ovrValWord}
        : hitMonitor ? {16'h0000, monitorWord}
        : hitChCfg ? chCfgWord : 32'h0000_0000;

    // zero wait states: data is captured in the setup cycle so the access phase answers at once
    assign pready = 1'b1;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clkEn && setupPhase) begin
            prdata <= pwrite ? 32'h0000_0000 : readWord;
            pslverr <= badAccess;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ovrEnable <= OVR_EN_RESET[NUM_CH-1:0];
            ovrValue <= OVR_VAL_RESET[NUM_CH-1:0];
        end else if (accessWrite) begin
            if (hitOvrEn) begin
                ovrEnable <= pwdata[NUM_CH-1:0]; // R11
            end
            if (hitOvrVal) begin
                ovrValue <= pwdata[NUM_CH-1:0]; // R12
            end
        end
    end

    // ------------------------------------------------------------------
    // sync pulse: pin synchroniser and rising-edge detect
    // ------------------------------------------------------------------
    logic syncMeta;
    logic syncStable;
    logic syncLast;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            syncMeta <= 1'b0;
            syncStable <= 1'b0;
            syncLast <= 1'b0;
        end else if (clkEn) begin
            syncMeta <= syncPulse;
            syncStable <= syncMeta;
            syncLast <= syncStable;
        end
    end

    wire syncEdge = syncStable & ~syncLast;

    // ------------------------------------------------------------------
    // unit tick enables
    // ------------------------------------------------------------------
    logic [NUM_UNITS-1:0] unitTick;

    // the clock is 25 ns, so both the 12.5 ns and 25 ns chains step every cycle
    assign unitTick[UNIT_12NS5] = 1'b1; // R21
    assign unitTick[UNIT_25NS] = 1'b1; // R21
    assign unitTick[UNIT_SYNC] = syncEdge; // R5 R6

    function automatic int unit_cycles(input int idx, input int msCycles);
        int cyc;
        cyc = msCycles;
        case (idx)
            2: cyc = CYC_50NS;
            3: cyc = CYC_100NS;
            4: cyc = CYC_1US;
            5: cyc = CYC_10US;
            6: cyc = CYC_100US;
            default: cyc = msCycles;
        endcase
        return cyc;
    endfunction : unit_cycles

    for (genvar u = UNIT_50NS; u <= UNIT_1MS; u++) begin : gen_prescale
        localparam logic [TICK_CNT_W-1:0] LAST = TICK_CNT_W'(unit_cycles(u, MS_TICK_CYCLES) - 1);
        logic [TICK_CNT_W-1:0] count;
        wire wrapNow = count == LAST;

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                count <= '0;
            end else if (clkEn) begin
                count <= wrapNow ? '0 : count + 1'b1;
            end
        end

        assign unitTick[u] = wrapNow; // R4
    end

    // ------------------------------------------------------------------
    // per-channel processing
    // ------------------------------------------------------------------
    wire faultActive = cpuError | logicStop; // R8 R9

    for (genvar c = 0; c < NUM_CH; c++) begin : gen_channel
        localparam int DIFF_IDX = c - NUM_SE;
        // only differential outputs 0 and 1 can take the ssi clock
        localparam bit SSI_CAPABLE = (c >= NUM_SE) && (DIFF_IDX < NUM_SSI); // R18
        localparam int SSI_IDX = SSI_CAPABLE ? DIFF_IDX : 0;

        wire ssiLock = SSI_CAPABLE ? ssiPresent[SSI_IDX] : 1'b0; // R16
        wire linkedOr = |linkSignals[c*LINKS +: LINKS]; // R17
        wire source = ssiLock ? ssiClock[SSI_IDX] : linkedOr; // R16

        // a locked channel behaves as if polarity, step, unit and fault policy held their reset values
        wire pol = ssiLock ? POL_RESET : cfgPol[c]; // R16
        wire [STEP_W-1:0] step = ssiLock ? STEP_RESET : cfgStep[c];
        wire [UNIT_W-1:0] unit = ssiLock ? UNIT_12NS5 : cfgUnit[c];
        wire [1:0] policy = ssiLock ? FAULT_OFF : cfgFault[c];

        wire polarized = source ^ pol; // R1

        logic [MAX_STEP-1:0] chain;
        wire chainTick = unitTick[unit];

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                chain <= '0;
            end else if (clkEn && chainTick) begin
                chain <= {chain[MAX_STEP-2:0], polarized}; // R21
            end
        end

        // 12.5 ns steps run on the 25 ns chain: half the step count, rounded up
        wire [STEP_W-1:0] halfStep = STEP_W'((step + 1'b1) >> 1); // R7
        wire isSync = unit == UNIT_SYNC;
        wire [STEP_W-1:0] tapSteps = isSync ? STEP_W'(1) // R5
            : (unit == UNIT_12NS5) ? halfStep : step; // R4
        wire [STEP_W-1:0] tapIdx = tapSteps - 1'b1;
        wire bypass = (step == STEP_RESET) && !isSync; // R2
        wire delayed = bypass ? polarized : chain[tapIdx[5:0]]; // R4 R7

        // policy level never passes through the polarity xor
        wire faultLevel = (policy == FAULT_ON) ? 1'b1
            : (policy == FAULT_HOLD) ? pinLevel[c] : 1'b0; // R8 R10
        wire nextLevel = faultActive ? faultLevel // R9 R10
            : ovrEnable[c] ? ovrValue[c] : delayed; // R13

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                pinLevel[c] <= 1'b0;
            end else if (clkEn) begin
                pinLevel[c] <= nextLevel;
            end
        end

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                cfgPol[c] <= POL_RESET; // R1
                cfgStep[c] <= STEP_RESET; // R2
                cfgUnit[c] <= UNIT_12NS5; // R3
                cfgFault[c] <= FAULT_OFF; // R8
            end else if (accessWrite && hitChCfg && chSel == 4'(c)) begin
                cfgPol[c] <= pwdata[POL_BIT]; // R1
                cfgStep[c] <= wrStep; // R2
                cfgUnit[c] <= wrUnit; // R3
                cfgFault[c] <= wrFault; // R8
            end
        end
    end

    // ------------------------------------------------------------------
    // terminals
    // ------------------------------------------------------------------
    assign seOut = pinLevel[NUM_SE-1:0]; // R19
    assign diffOutP = pinLevel[NUM_CH-1:NUM_SE]; // R19 R20
    assign diffOutN = ~pinLevel[NUM_CH-1:NUM_SE]; // R20
endmodule : output_stage_delay_force
`default_nettype wire

// *** pkg/output_stage_pkg.sv ***
// shared constants for the output stage with delay, fault policy and override
`default_nettype none
package output_stage_pkg;
    // ------------------------------------------------------------------
    // channel layout
    // ------------------------------------------------------------------
    localparam int NUM_SE = 8;
    localparam int NUM_DIFF = 6;
    localparam int NUM_CH = NUM_SE + NUM_DIFF;
    localparam int LINKS = 4;
    localparam int WORD_W = 16;
    localparam int NUM_SSI = 2;
    localparam int MAX_STEP = 64;
    localparam int STEP_W = 7;
    localparam int UNIT_W = 4;
    localparam int NUM_UNITS = 9;
    localparam int ADDR_W = 12;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OVR_EN_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] OVR_VAL_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] MONITOR_OFS = 12'h008;
    localparam logic [ADDR_W-1:0] CHCFG_BASE_OFS = 12'h040;

    // channel config word fields
    localparam int POL_BIT = 0;
    localparam int STEP_LSB = 8;
    localparam int UNIT_LSB = 16;
    localparam int FAULT_LSB = 20;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic POL_RESET = 1'b0;
    localparam logic [STEP_W-1:0] STEP_RESET = 7'h00;
    localparam logic [WORD_W-1:0] OVR_EN_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] OVR_VAL_RESET = 16'h0000;

    typedef enum logic [UNIT_W-1:0] {
        UNIT_12NS5 = 4'h0,
        UNIT_25NS = 4'h1,
        UNIT_50NS = 4'h2,
        UNIT_100NS = 4'h3,
        UNIT_1US = 4'h4,
        UNIT_10US = 4'h5,
        UNIT_100US = 4'h6,
        UNIT_1MS = 4'h7,
        UNIT_SYNC = 4'h8
    } delay_unit_t;

    typedef enum logic [1:0] {
        FAULT_OFF = 2'h0,
        FAULT_ON = 2'h1,
        FAULT_HOLD = 2'h2
    } fault_policy_t;

    // ------------------------------------------------------------------
    // timing: unit times in ps, cycle counts derived from the clock period
    // ------------------------------------------------------------------
    localparam longint CLK_PERIOD_PS = 25000;
    localparam longint UNIT_50NS_PS = 50000;
    localparam longint UNIT_100NS_PS = 100000;
    localparam longint UNIT_1US_PS = 1000000;
    localparam longint UNIT_10US_PS = 10000000;
    localparam longint UNIT_100US_PS = 100000000;
    localparam longint UNIT_1MS_PS = 1000000000;
    localparam int CYC_50NS = int'(UNIT_50NS_PS / CLK_PERIOD_PS);
    localparam int CYC_100NS = int'(UNIT_100NS_PS / CLK_PERIOD_PS);
    localparam int CYC_1US = int'(UNIT_1US_PS / CLK_PERIOD_PS);
    localparam int CYC_10US = int'(UNIT_10US_PS / CLK_PERIOD_PS);
    localparam int CYC_100US = int'(UNIT_100US_PS / CLK_PERIOD_PS);
    localparam int CYC_1MS = int'(UNIT_1MS_PS / CLK_PERIOD_PS);
    localparam int TICK_CNT_W = 16;
endpackage : output_stage_pkg
`default_nettype wire

// *** testbench/field_load.sv ***
// load model: field devices reading the single-ended and differential outputs
`timescale 1ns/1ps
`default_nettype none
module field_load (
    input wire logic [output_stage_pkg::NUM_SE-1:0] seOut,
    input wire logic [output_stage_pkg::NUM_DIFF-1:0] diffOutP,
    input wire logic [output_stage_pkg::NUM_DIFF-1:0] diffOutN,
    output logic [output_stage_pkg::NUM_CH-1:0] loadWord
);
    import output_stage_pkg::*;
    // ----
    // receivers
    // ----
    // a diff receiver reads on only when the legs oppose, so equal legs show as off
    assign loadWord = {diffOutP & ~diffOutN, seOut};
endmodule : field_load
`default_nettype wire

// *** testbench/output_stage_checker.sv ***
// port-level assertion checker for the output stage
`timescale 1ns/1ps
`default_nettype none
module output_stage_checker #(
    parameter int MS_TICK_CYCLES = 50
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [output_stage_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [output_stage_pkg::NUM_SSI-1:0] ssiPresent,
    input wire logic [output_stage_pkg::NUM_SSI-1:0] ssiClock,
    input wire logic cpuError,
    input wire logic logicStop,
    input wire logic [output_stage_pkg::NUM_SE-1:0] seOut,
    input wire logic [output_stage_pkg::NUM_DIFF-1:0] diffOutP,
    input wire logic [output_stage_pkg::NUM_DIFF-1:0] diffOutN
);
    import output_stage_pkg::*;
    // ----
    // shadow of written state, then properties
    // ----
    logic [13:0] ovrEn;
    logic [13:0] ovrVal;
    logic [1:0] fault0;
    logic [1:0] fault1;
    wire wrAcc = psel && penable && pwrite && clkEn;
    wire setup = psel && !penable && clkEn;
    wire faultOn = cpuError || logicStop;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ovrEn <= 14'h0;
            ovrVal <= 14'h0;
            fault0 <= 2'h0;
            fault1 <= 2'h0;
        end else if (wrAcc) begin
            if (paddr == OVR_EN_OFS) ovrEn <= pwdata[13:0];
            if (paddr == OVR_VAL_OFS) ovrVal <= pwdata[13:0];
            if (paddr == CHCFG_BASE_OFS) fault0 <= pwdata[21:20];
            if (paddr == CHCFG_BASE_OFS + 12'h004) fault1 <= pwdata[21:20];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    property p_diff_comp; diffOutN == ~diffOutP; endproperty
    a_diff_comp: assert property (p_diff_comp) else $error("diff legs not complementary");
    property p_ovr; clkEn && !faultOn && ovrEn[0] |=> seOut[0] == $past(ovrVal[0]); endproperty
    a_ovr: assert property (p_ovr) else $error("override level not driven");
    property p_fault_lvl;
        clkEn && faultOn && fault0 != FAULT_HOLD |=> seOut[0] == (fault0 == FAULT_ON);
    endproperty
    a_fault_lvl: assert property (p_fault_lvl) else $error("fault level wrong");
    property p_hold; clkEn && faultOn && fault1 == FAULT_HOLD |=> $stable(seOut[1]); endproperty
    a_hold: assert property (p_hold) else $error("hold policy moved the output");
    property p_mon;
        setup && !pwrite && paddr == MONITOR_OFS |=> prdata == {18'h00000, $past(diffOutP), $past(seOut)};
    endproperty
    a_mon: assert property (p_mon) else $error("monitor read wrong");
    property p_wr_mon; setup && pwrite && paddr == MONITOR_OFS |=> pslverr; endproperty
    a_wr_mon: assert property (p_wr_mon) else $error("monitor write accepted");
    property p_unmapped; setup && paddr == 12'h020 |=> pslverr && prdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    property p_ssi;
        clkEn && ssiPresent[0] && !faultOn && !ovrEn[8] |=> diffOutP[0] == $past(ssiClock[0]);
    endproperty
    a_ssi: assert property (p_ssi) else $error("ssi clock not routed");
    c_fault: cover property (faultOn && fault1 == FAULT_HOLD);
    c_ovr: cover property (ovrEn[0] && ovrVal[0]);
    c_ssi: cover property (ssiPresent[0] && ssiClock[0]);
endmodule : output_stage_checker
bind output_stage_delay_force output_stage_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) output_stage_checker_inst (
    .ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .ssiPresent(ssiPresent),
    .ssiClock(ssiClock), .cpuError(cpuError), .logicStop(logicStop), .seOut(seOut),
    .diffOutP(diffOutP), .diffOutN(diffOutN));
`default_nettype wire

// *** testbench/testbench.sv ***
// self-checking testbench for the output stage
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import output_stage_pkg::*;
    // ----
    // stimulus, bus tasks and tests
    // ----
    logic ref_clk = 1'b0, srst = 1'b1, clkEn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic syncPulse = 1'b0, cpuError = 1'b0, logicStop = 1'b0, lastErr;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [NUM_CH*LINKS-1:0] link = '0;
    logic [NUM_SSI-1:0] ssiPresent = '0, ssiClock = '0;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [NUM_SE-1:0] seOut;
    wire [NUM_DIFF-1:0] diffOutP, diffOutN;
    wire [NUM_CH-1:0] loadWord;
    int n_mismatch = 0;
    int num_checks = 0;
    output_stage_delay_force #(.MS_TICK_CYCLES(50)) output_stage_delay_force_inst (
        .ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .linkSignals(link), .ssiPresent(ssiPresent), .ssiClock(ssiClock), .syncPulse(syncPulse),
        .cpuError(cpuError), .logicStop(logicStop), .seOut(seOut), .diffOutP(diffOutP), .diffOutN(diffOutN));
    field_load field_load_inst (.seOut(seOut), .diffOutP(diffOutP), .diffOutN(diffOutN), .loadWord(loadWord));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // an edge always passes first, so psel is never driven twice in one step
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd
    function automatic logic [ADDR_W-1:0] cfgA(input int c);
        return CHCFG_BASE_OFS + ADDR_W'(4 * c);
    endfunction : cfgA
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    initial begin
        tick(5000);
        n_mismatch++;
        final_report();
    end
    initial begin
        tick(10);
        srst <= 1'b0;
        for (int c = 0; c < NUM_CH; c++) rd(cfgA(c), 32'h0);
        rd(OVR_EN_OFS, 32'h0);
        $display("test defaults done");
        link[3] <= 1'b1;
        tick(2);
        chk(seOut[0], 1'b1);
        wr(cfgA(0), 32'h1);
        tick(2);
        chk(seOut[0], 1'b0);
        wr(cfgA(0), 32'h0);
        link[3] <= 1'b0;
        $display("test polarity done");
        wr(cfgA(1), 32'h0001_0a00);
        link[4] <= 1'b1;
        tick(8);
        chk(seOut[1], 1'b0);
        tick(6);
        chk(seOut[1], 1'b1);
        wr(cfgA(2), 32'h0007_0200);
        link[8] <= 1'b1;
        tick(40);
        chk(seOut[2], 1'b0);
        tick(120);
        chk(seOut[2], 1'b1);
        for (int u = 0; u < NUM_UNITS; u++) begin
            wr(cfgA(3), 32'(u) << 16 | 32'h4000);
            rd(cfgA(3), 32'(u) << 16 | 32'h4000);
        end
        $display("test delay done");
        wr(cfgA(4), 32'h0008_0500);
        link[16] <= 1'b1;
        tick(20);
        chk(seOut[4], 1'b0);
        syncPulse <= 1'b1;
        tick(8);
        chk(seOut[4], 1'b1);
        syncPulse <= 1'b0;
        link[16] <= 1'b0;
        tick(8);
        chk(seOut[4], 1'b1);
        rd(MONITOR_OFS, 32'h0000_0016);
        $display("test sync done");
        wr(OVR_VAL_OFS, 32'h0000_1555);
        wr(OVR_EN_OFS, 32'hffff_ffff);
        rd(OVR_EN_OFS, 32'h0000_3fff);
        tick(2);
        chk({diffOutP, seOut}, 32'h1555);
        chk(diffOutN, 32'h2a);
        rd(MONITOR_OFS, 32'h0000_1555);
        chk(loadWord, 32'h1555);
        wr(OVR_EN_OFS, 32'h0);
        $display("test override done");
        wr(cfgA(0), 32'h1);
        wr(cfgA(1), 32'h0021_0a00);
        wr(cfgA(6), 32'h0010_0000);
        cpuError <= 1'b1;
        link[4] <= 1'b0;
        tick(20);
        chk(seOut[0], 1'b0);
        chk(seOut[1], 1'b1);
        chk(seOut[6], 1'b1);
        cpuError <= 1'b0;
        logicStop <= 1'b1;
        tick(2);
        chk(seOut[1], 1'b1);
        chk(seOut[6], 1'b1);
        logicStop <= 1'b0;
        tick(20);
        chk(seOut[1], 1'b0);
        $display("test fault done");
        clkEn <= 1'b0;
        link[0] <= 1'b1;
        tick(4);
        chk(seOut[0], 1'b1);
        clkEn <= 1'b1;
        tick(2);
        chk(seOut[0], 1'b0);
        wr(cfgA(8), 32'h0000_0a01);
        wr(cfgA(9), 32'h0000_0a01);
        ssiPresent <= 2'b11;
        ssiClock <= 2'b11;
        tick(2);
        chk(diffOutP[1:0], 32'h3);
        ssiClock <= 2'b00;
        tick(2);
        chk(diffOutP[1:0], 32'h0);
        rd(cfgA(8), 32'h0000_0a01);
        ssiPresent <= 2'b00;
        tick(14);
        chk(diffOutP[1:0], 32'h3);
        $display("test ssi done");
        wr(MONITOR_OFS, 32'h0000_00ff);
        chk(lastErr, 1'b1);
        rd(12'h020, 32'h0);
        chk(lastErr, 1'b1);
        rd(OVR_VAL_OFS, 32'h0000_1555);
        chk(lastErr, 1'b0);
        $display("test refusals done");
        // 50 ns unit, 3 steps: two-cycle prescaler, first tick may land one cycle late
        wr(cfgA(5), 32'h0002_0300);
        link[20] <= 1'b1;
        tick(3);
        chk(seOut[5], 1'b0);
        tick(6);
        chk(seOut[5], 1'b1);
        $display("test prescaled unit done");
        // mid-run reset: settings return to defaults, channel 0 stops inverting
        srst <= 1'b1;
        tick(3);
        srst <= 1'b0;
        rd(cfgA(0), 32'h0);
        rd(OVR_VAL_OFS, 32'h0);
        chk(seOut[0], 1'b1);
        $display("test reset done");
        final_report();
    end
endmodule : testbench
`default_nettype wire
